// >>> design/aopc_defs.svh
`ifndef AOPC_DEFS_SVH
`define AOPC_DEFS_SVH

// Register byte offsets
`define AOPC_OFS_CONTROL    8'h00
`define AOPC_OFS_STATUS     8'h04
`define AOPC_OFS_MASK       8'h08
`define AOPC_OFS_STATE      8'h0C
`define AOPC_OFS_OUTPUT     8'h14

// Control fields
`define AOPC_CTL_PWDN       0
`define AOPC_CTL_STBY       1
`define AOPC_CTL_REGFMT     2
`define AOPC_CTL_FMT_LO     4
`define AOPC_CTL_FMT_HI     5
`define AOPC_CTL_DCOINV     6
`define AOPC_CTL_RESET      32'h0000_0000

// Output register fields, one disable bit per channel
`define AOPC_OUT_DIS_A      0
`define AOPC_OUT_DIS_B      1
`define AOPC_OUT_RESET      32'h0000_0000

// Status and mask fields
`define AOPC_ST_OR_A        0
`define AOPC_ST_OR_B        1
`define AOPC_ST_WAKE        2
`define AOPC_ST_DOWN        3
`define AOPC_ST_W           4
`define AOPC_MASK_RESET     4'h0

// Code points of the 12-bit output
`define AOPC_CODE_MIN       12'h000
`define AOPC_CODE_MID       12'h800
`define AOPC_CODE_MAX       12'hFFF

// Timing
`define AOPC_LATENCY        12
`define AOPC_CLK_NS         4
`define AOPC_STBY_WAKE_NS   200
`define AOPC_STBY_WAKE_CYC  ((`AOPC_STBY_WAKE_NS + `AOPC_CLK_NS - 1) / `AOPC_CLK_NS)

`endif

// >>> design/aopc_pkg.sv
package aopc_pkg;

	// Power sequencing, Gray along RUN -> DOWN -> WAKE
	typedef enum logic [1:0] {
		AOPC_RUN  = 2'b00,
		AOPC_DOWN = 2'b01,
		AOPC_WAKE = 2'b11,
		AOPC_STBY = 2'b10
	} aopc_state_e;

	// Output code formats
	typedef enum logic [1:0] {
		AOPC_FMT_OFFSET = 2'b00,
		AOPC_FMT_TWOS   = 2'b01,
		AOPC_FMT_GRAY   = 2'b10
	} aopc_fmt_e;

	typedef logic [31:0] aopc_word_t;

endpackage

// >>> design/aopc_delay.sv
`timescale 1ns/1ns
`default_nettype none

module aopc_delay #(
	parameter int WIDTH = 26,
	parameter int DEPTH = 12
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Advance strobe and data
	input  wire logic             adv,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    ptr_reg;
	logic [WIDTH-1:0] dout_reg;

	// Ring pointer, the oldest slot is the one about to be overwritten
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ptr_reg <= '0;
		end else if (adv) begin
			ptr_reg <= (ptr_reg == LAST) ? '0 : ptr_reg + 1'b1;
		end
	end

	// Storage has no reset, contents before the first fill are don't-care
	always_ff @(posedge clk) begin
		if (adv) begin
			mem[ptr_reg] <= din;
		end
	end

	// Registered read of the slot written DEPTH advances ago
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dout_reg <= '0;
		end else if (adv) begin
			dout_reg <= mem[ptr_reg];
		end
	end

	assign dout = dout_reg;

endmodule

`default_nettype wire

// >>> design/aopc_axil.sv
`timescale 1ns/1ns
`default_nettype none

module aopc_axil (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// AXI4-Lite write channels
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read channels
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Register file side
	output logic             wr_en,
	output logic [7:0]       wr_addr,
	output logic [31:0]      wr_data,
	output logic [3:0]       wr_strb,
	input  wire logic        wr_err,
	output logic             rd_en,
	output logic [7:0]       rd_addr,
	input  wire logic [31:0] rd_data,
	input  wire logic        rd_err
);

	logic aw_full_reg;
	logic w_full_reg;
	logic wr_en_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic [7:0] aw_reg;
	logic [31:0] wd_reg;
	logic [3:0] ws_reg;
	logic rd_en_reg;
	logic [7:0] ar_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	assign awready = !aw_full_reg && !bvalid_reg && !wr_en_reg;
	assign wready  = !w_full_reg && !bvalid_reg && !wr_en_reg;
	assign arready = !rd_en_reg && !rvalid_reg;

	// Address and data are latched separately, either may come first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			aw_reg      <= 8'h00;
			wd_reg      <= 32'h0000_0000;
			ws_reg      <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_full_reg <= 1'b1;
				aw_reg      <= awaddr;
			end else if (wr_en_reg) begin
				aw_full_reg <= 1'b0;
			end
			if (wvalid && wready) begin
				w_full_reg <= 1'b1;
				wd_reg     <= wdata;
				ws_reg     <= wstrb;
			end else if (wr_en_reg) begin
				w_full_reg <= 1'b0;
			end
		end
	end

	// One write pulse once both halves are held, response the cycle after
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_en_reg  <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg  <= 2'b00;
		end else begin
			wr_en_reg <= aw_full_reg && w_full_reg && !wr_en_reg && !bvalid_reg;
			if (wr_en_reg) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= wr_err ? 2'b10 : 2'b00;
			end else if (bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Read pulse after the address is taken, data captured on that pulse
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_en_reg  <= 1'b0;
			ar_reg     <= 8'h00;
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0000_0000;
			rresp_reg  <= 2'b00;
		end else begin
			rd_en_reg <= arvalid && arready;
			if (arvalid && arready) begin
				ar_reg <= araddr;
			end
			if (rd_en_reg) begin
				rvalid_reg <= 1'b1;
				rdata_reg  <= rd_data;
				rresp_reg  <= rd_err ? 2'b10 : 2'b00;
			end else if (rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	assign wr_en   = wr_en_reg;
	assign wr_addr = aw_reg;
	assign wr_data = wd_reg;
	assign wr_strb = ws_reg;
	assign bvalid  = bvalid_reg;
	assign bresp   = bresp_reg;
	assign rd_en   = rd_en_reg;
	assign rd_addr = ar_reg;
	assign rvalid  = rvalid_reg;
	assign rdata   = rdata_reg;
	assign rresp   = rresp_reg;

endmodule

`default_nettype wire

// >>> design/aopc_top.sv
// Function
// - Power-down from pin high or register bit; all drivers go high impedance.
// - Power-down pin low returns the converter to normal operation.
// - Register standby mode keeps reference up, giving a fixed short wake-up.
// - Wake-up time grows with time spent powered down.
// - Pin mode: format pin low gives offset binary, high gives twos complement.
// - Register mode selects offset binary, twos complement or gray code.
// - Output-disable pin low enables the data drivers, high puts them in high impedance; the data clock driver ignores the pin.
// - Output register holds an independent disable bit per channel.
// - Each sample appears twelve sample clocks later, updated after rising edge.
// - Two data clocks, data valid at rising edge unless polarity inverted.
// - Saturating codes; out-of-range flag beyond half LSB past full scale.
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "aopc_defs.svh"

module aopc_top #(
	parameter int IN_W       = 14,
	parameter int LATENCY    = `AOPC_LATENCY,
	parameter int DOWN_CW    = 20,
	parameter int WAKE_SHIFT = 4
) (
	// Clock and reset
	input  wire logic            CLK,
	input  wire logic            RST,
	// AXI4-Lite register bus
	input  wire logic [7:0]      S_AXI_AWADDR,
	input  wire logic            S_AXI_AWVALID,
	output logic                 S_AXI_AWREADY,
	input  wire logic [31:0]     S_AXI_WDATA,
	input  wire logic [3:0]      S_AXI_WSTRB,
	input  wire logic            S_AXI_WVALID,
	output logic                 S_AXI_WREADY,
	output logic [1:0]           S_AXI_BRESP,
	output logic                 S_AXI_BVALID,
	input  wire logic            S_AXI_BREADY,
	input  wire logic [7:0]      S_AXI_ARADDR,
	input  wire logic            S_AXI_ARVALID,
	output logic                 S_AXI_ARREADY,
	output aopc_pkg::aopc_word_t S_AXI_RDATA,
	output logic [1:0]           S_AXI_RRESP,
	output logic                 S_AXI_RVALID,
	input  wire logic            S_AXI_RREADY,
	// Sample clock and converter samples, half-LSB units, signed
	input  wire logic            SAMPLE_CLK,
	input  wire logic [IN_W-1:0] SAMPLE_A,
	input  wire logic [IN_W-1:0] SAMPLE_B,
	// Control pins
	input  wire logic            POWER_DOWN_REQUEST,
	input  wire logic            OUTPUT_DISABLE_PIN,
	input  wire logic            FORMAT_SELECT_PIN,
	// Channel A outputs
	output logic [11:0]          DATA_A,
	output logic                 OR_A,
	output logic                 DATA_A_OE,
	// Channel B outputs
	output logic [11:0]          DATA_B,
	output logic                 OR_B,
	output logic                 DATA_B_OE,
	// Data clocks
	output logic                 DATA_CLOCK_OUT_A,
	output logic                 DATA_CLOCK_OUT_B,
	output logic                 DATA_CLOCK_OE,
	// Interrupt
	output logic                 IRQ
);
	import aopc_pkg::*;

	localparam logic [DOWN_CW-1:0] STBY_WAKE = DOWN_CW'(`AOPC_STBY_WAKE_CYC);
	localparam logic [DOWN_CW-1:0] DOWN_MAX  = '1;
	localparam logic [DOWN_CW-1:0] ONE       = DOWN_CW'(1);

	// Quantise to 12-bit offset binary with out-of-range flag
	function automatic logic [12:0] quantise(input logic signed [IN_W-1:0] x);
		logic signed [IN_W-1:0] q;
		q = x >>> 1;
		if (x > IN_W'(4095)) begin
			quantise = {1'b1, `AOPC_CODE_MAX};
		end else if (x < -IN_W'(4097)) begin
			quantise = {1'b1, `AOPC_CODE_MIN};
		end else if (q < -IN_W'(2048)) begin
			quantise = {1'b0, `AOPC_CODE_MIN};
		end else begin
			quantise = {1'b0, 12'(q + IN_W'(2048))};
		end
	endfunction

	// Recode an offset binary word in the chosen format
	function automatic logic [11:0] recode(input logic [11:0] ob, input aopc_fmt_e f);
		unique case (f)
			AOPC_FMT_TWOS: recode = ob ^ `AOPC_CODE_MID;
			AOPC_FMT_GRAY: recode = ob ^ (ob >> 1);
			default:       recode = ob;
		endcase
	endfunction

	// Byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				merge[i*8 +: 8] = d[i*8 +: 8];
			end
		end
	endfunction

	logic [2:0]      sclk_sync_reg;
	logic [1:0]      pd_sync_reg;
	logic [1:0]      oe_sync_reg;
	logic [1:0]      fmt_sync_reg;
	logic [IN_W-1:0] sa_s1_reg;
	logic [IN_W-1:0] sa_s2_reg;
	logic [IN_W-1:0] sb_s1_reg;
	logic [IN_W-1:0] sb_s2_reg;
	logic            sclk_rise;
	logic [31:0]     control_reg;
	logic [31:0]     output_reg;
	logic [`AOPC_ST_W-1:0] status_reg;
	logic [`AOPC_ST_W-1:0] status_next;
	logic [`AOPC_ST_W-1:0] mask_reg;
	logic [`AOPC_ST_W-1:0] events;
	aopc_state_e     state_reg;
	logic [DOWN_CW-1:0] down_cnt_reg;
	logic [DOWN_CW-1:0] wake_cnt_reg;
	logic            pd_req;
	logic            stby_req;
	logic            adv;
	logic [25:0]     pipe_in;
	logic [25:0]     pipe_out;
	aopc_fmt_e       fmt;
	logic [11:0]     data_a_reg;
	logic [11:0]     data_b_reg;
	logic            or_a_reg;
	logic            or_b_reg;
	logic            oe_a_reg;
	logic            oe_b_reg;
	logic            dck_reg;
	logic            dck_oe_reg;
	logic            irq_reg;
	logic            wr_en;
	logic [7:0]      wr_addr;
	logic [31:0]     wr_data;
	logic [3:0]      wr_strb;
	logic            wr_err;
	logic            rd_en;
	logic [7:0]      rd_addr;
	logic [31:0]     rd_data;
	logic            rd_err;

	aopc_axil u_axil (
		.clk     (CLK),
		.rst     (RST),
		.awaddr  (S_AXI_AWADDR),
		.awvalid (S_AXI_AWVALID),
		.awready (S_AXI_AWREADY),
		.wdata   (S_AXI_WDATA),
		.wstrb   (S_AXI_WSTRB),
		.wvalid  (S_AXI_WVALID),
		.wready  (S_AXI_WREADY),
		.bresp   (S_AXI_BRESP),
		.bvalid  (S_AXI_BVALID),
		.bready  (S_AXI_BREADY),
		.araddr  (S_AXI_ARADDR),
		.arvalid (S_AXI_ARVALID),
		.arready (S_AXI_ARREADY),
		.rdata   (S_AXI_RDATA),
		.rresp   (S_AXI_RRESP),
		.rvalid  (S_AXI_RVALID),
		.rready  (S_AXI_RREADY),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_err  (wr_err),
		.rd_en   (rd_en),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_err  (rd_err)
	);

	// Two-stage synchronisers; third sample-clock stage feeds the edge detector
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sclk_sync_reg <= 3'h0;
			pd_sync_reg   <= 2'h0;
			oe_sync_reg   <= 2'h3;
			fmt_sync_reg  <= 2'h0;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[1:0], SAMPLE_CLK};
			pd_sync_reg   <= {pd_sync_reg[0], POWER_DOWN_REQUEST};
			oe_sync_reg   <= {oe_sync_reg[0], OUTPUT_DISABLE_PIN};
			fmt_sync_reg  <= {fmt_sync_reg[0], FORMAT_SELECT_PIN};
		end
	end

	// Sample words are only read at a sample edge, well after they settle
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sa_s1_reg <= '0;
			sa_s2_reg <= '0;
			sb_s1_reg <= '0;
			sb_s2_reg <= '0;
		end else begin
			sa_s1_reg <= SAMPLE_A;
			sa_s2_reg <= sa_s1_reg;
			sb_s1_reg <= SAMPLE_B;
			sb_s2_reg <= sb_s1_reg;
		end
	end

	assign sclk_rise = sclk_sync_reg[1] && !sclk_sync_reg[2];
	assign pd_req    = pd_sync_reg[1] || control_reg[`AOPC_CTL_PWDN];
	assign stby_req  = control_reg[`AOPC_CTL_STBY];

	// Power sequencing; the down counter models charge lost while off
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_reg    <= AOPC_RUN;
			down_cnt_reg <= '0;
			wake_cnt_reg <= '0;
		end else begin
			unique case (state_reg)
				AOPC_RUN: begin
					if (pd_req) begin
						state_reg    <= AOPC_DOWN;
						down_cnt_reg <= '0;
					end else if (stby_req) begin
						state_reg <= AOPC_STBY;
					end
				end
				AOPC_DOWN: begin
					if (down_cnt_reg != DOWN_MAX) begin
						down_cnt_reg <= down_cnt_reg + 1'b1;
					end
					if (!pd_req) begin
						state_reg    <= AOPC_WAKE;
						wake_cnt_reg <= (down_cnt_reg >> WAKE_SHIFT) | ONE;
					end
				end
				AOPC_STBY: begin
					if (pd_req) begin
						state_reg    <= AOPC_DOWN;
						down_cnt_reg <= '0;
					end else if (!stby_req) begin
						state_reg    <= AOPC_WAKE;
						wake_cnt_reg <= STBY_WAKE;
					end
				end
				AOPC_WAKE: begin
					if (pd_req) begin
						state_reg    <= AOPC_DOWN;
						down_cnt_reg <= '0;
					end else if (stby_req) begin
						state_reg <= AOPC_STBY;
					end else if (wake_cnt_reg == ONE) begin
						state_reg <= AOPC_RUN;
					end else begin
						wake_cnt_reg <= wake_cnt_reg - 1'b1;
					end
				end
			endcase
		end
	end

	// The converter only clocks its pipeline while running or waking
	assign adv     = sclk_rise && (state_reg == AOPC_RUN || state_reg == AOPC_WAKE);
	assign pipe_in = {quantise(sb_s2_reg), quantise(sa_s2_reg)};

	aopc_delay #(
		.WIDTH (26),
		.DEPTH (LATENCY - 1)
	) u_delay (
		.clk  (CLK),
		.rst  (RST),
		.adv  (adv),
		.din  (pipe_in),
		.dout (pipe_out)
	);

	// Pin mode offers two formats, register mode adds gray
	always_comb begin
		if (control_reg[`AOPC_CTL_REGFMT]) begin
			fmt = aopc_fmt_e'(control_reg[`AOPC_CTL_FMT_HI:`AOPC_CTL_FMT_LO]);
		end else begin
			fmt = fmt_sync_reg[1] ? AOPC_FMT_TWOS : AOPC_FMT_OFFSET;
		end
	end

	// Output word register, changes just after the sample edge
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			data_a_reg <= 12'h000;
			data_b_reg <= 12'h000;
			or_a_reg   <= 1'b0;
			or_b_reg   <= 1'b0;
		end else if (adv) begin
			data_a_reg <= recode(pipe_out[11:0], fmt);
			or_a_reg   <= pipe_out[12];
			data_b_reg <= recode(pipe_out[24:13], fmt);
			or_b_reg   <= pipe_out[25];
		end
	end

	// Data clock lags data by half a period so its rising edge is mid-word
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			dck_reg <= 1'b0;
		end else begin
			dck_reg <= !sclk_sync_reg[2] ^ control_reg[`AOPC_CTL_DCOINV];
		end
	end

	// Driver enables; the pin is slow, not meant for bus sharing
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			oe_a_reg   <= 1'b0;
			oe_b_reg   <= 1'b0;
			dck_oe_reg <= 1'b0;
		end else begin
			oe_a_reg   <= state_reg == AOPC_RUN && !oe_sync_reg[1] && !output_reg[`AOPC_OUT_DIS_A];
			oe_b_reg   <= state_reg == AOPC_RUN && !oe_sync_reg[1] && !output_reg[`AOPC_OUT_DIS_B];
			dck_oe_reg <= state_reg == AOPC_RUN;
		end
	end

	// Control and output registers
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			control_reg <= `AOPC_CTL_RESET;
			output_reg  <= `AOPC_OUT_RESET;
			mask_reg    <= `AOPC_MASK_RESET;
		end else if (wr_en) begin
			if (wr_addr == `AOPC_OFS_CONTROL) begin
				control_reg <= merge(control_reg, wr_data, wr_strb) & 32'h0000_0077;
			end
			if (wr_addr == `AOPC_OFS_OUTPUT) begin
				output_reg <= merge(output_reg, wr_data, wr_strb) & 32'h0000_0003;
			end
			if (wr_addr == `AOPC_OFS_MASK && wr_strb[0]) begin
				mask_reg <= wr_data[`AOPC_ST_W-1:0];
			end
		end
	end

	// Sticky events; a new event wins over the read that clears
	always_comb begin
		events = '0;
		events[`AOPC_ST_OR_A] = adv && pipe_out[12];
		events[`AOPC_ST_OR_B] = adv && pipe_out[25];
		events[`AOPC_ST_WAKE] = state_reg == AOPC_WAKE && wake_cnt_reg == ONE && !pd_req && !stby_req;
		events[`AOPC_ST_DOWN] = state_reg != AOPC_DOWN && pd_req;
		status_next = status_reg;
		if (rd_en && rd_addr == `AOPC_OFS_STATUS) begin
			status_next = '0;
		end
		status_next = status_next | events;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			status_reg <= '0;
			irq_reg    <= 1'b0;
		end else begin
			status_reg <= status_next;
			irq_reg    <= |(status_next & mask_reg);
		end
	end

	// Read decode and error answer for unmapped offsets
	always_comb begin
		rd_err = 1'b0;
		unique case (rd_addr)
			`AOPC_OFS_CONTROL: rd_data = control_reg;
			`AOPC_OFS_STATUS:  rd_data = {28'h0, status_reg};
			`AOPC_OFS_MASK:    rd_data = {28'h0, mask_reg};
			`AOPC_OFS_STATE:   rd_data = {24'h0, 1'b0, fmt_sync_reg[1], oe_sync_reg[1], pd_sync_reg[1], fmt, state_reg};
			`AOPC_OFS_OUTPUT:  rd_data = output_reg;
			default: begin
				rd_data = 32'h0000_0000;
				rd_err  = 1'b1;
			end
		endcase
	end

	assign wr_err = !(wr_addr == `AOPC_OFS_CONTROL || wr_addr == `AOPC_OFS_MASK ||
		wr_addr == `AOPC_OFS_OUTPUT || wr_addr == `AOPC_OFS_STATUS || wr_addr == `AOPC_OFS_STATE);

	assign DATA_A           = data_a_reg;
	assign OR_A             = or_a_reg;
	assign DATA_A_OE        = oe_a_reg;
	assign DATA_B           = data_b_reg;
	assign OR_B             = or_b_reg;
	assign DATA_B_OE        = oe_b_reg;
	assign DATA_CLOCK_OUT_A = dck_reg;
	assign DATA_CLOCK_OUT_B = dck_reg;
	assign DATA_CLOCK_OE    = dck_oe_reg;
	assign IRQ              = irq_reg;

endmodule

`default_nettype wire

// >>> dv/aopc_checker_sva.sv
`timescale 1ns/1ns
`default_nettype none
module aopc_checker (
	// Clock and reset
	input wire logic                 CLK,
	input wire logic                 RST,
	// Register bus handshakes
	input wire logic                 S_AXI_AWVALID,
	input wire logic                 S_AXI_AWREADY,
	input wire logic                 S_AXI_WVALID,
	input wire logic                 S_AXI_WREADY,
	input wire logic [1:0]           S_AXI_BRESP,
	input wire logic                 S_AXI_BVALID,
	input wire logic                 S_AXI_BREADY,
	input wire logic                 S_AXI_ARVALID,
	input wire logic                 S_AXI_ARREADY,
	input wire aopc_pkg::aopc_word_t S_AXI_RDATA,
	input wire logic                 S_AXI_RVALID,
	input wire logic                 S_AXI_RREADY,
	// Pins and drivers
	input wire logic                 POWER_DOWN_REQUEST,
	input wire logic                 OUTPUT_DISABLE_PIN,
	input wire logic                 DATA_A_OE,
	input wire logic                 DATA_B_OE,
	input wire logic                 DATA_CLOCK_OUT_A,
	input wire logic                 DATA_CLOCK_OUT_B,
	input wire logic                 DATA_CLOCK_OE
);
	import aopc_pkg::*;
	// One domain, so clock and reset are given once
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	// Six cycles cover the pin synchroniser and the driver register
	a_pd_off: assert property (POWER_DOWN_REQUEST [*6] |-> !DATA_A_OE && !DATA_B_OE && !DATA_CLOCK_OE)
		else $error("drivers on during power-down");
	a_oe_pin: assert property (OUTPUT_DISABLE_PIN [*6] |-> !DATA_A_OE && !DATA_B_OE)
		else $error("drivers on while disable pin high");
	a_oe_cause: assert property ($rose(DATA_A_OE) |-> !$past(OUTPUT_DISABLE_PIN, 3) && !$past(POWER_DOWN_REQUEST, 4))
		else $error("driver enabled while a disable was active");
	a_dco_pair: assert property (DATA_CLOCK_OUT_A == DATA_CLOCK_OUT_B)
		else $error("data clocks differ");
	// Bus answers stand until taken and come at a fixed latency; one write in flight at a time
	a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write response dropped early");
	a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read data dropped early");
	a_w_resp: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##3 S_AXI_BVALID)
		else $error("write response late");
	a_r_resp: assert property (S_AXI_ARVALID && S_AXI_ARREADY |-> ##2 S_AXI_RVALID)
		else $error("read response late");
	a_aw_block: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY)
		else $error("second write taken in flight");
endmodule
bind aopc_top aopc_checker aopc_checker_inst (.CLK(CLK), .RST(RST), .S_AXI_AWVALID(S_AXI_AWVALID),
	.S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
	.S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
	.S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
	.S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .POWER_DOWN_REQUEST(POWER_DOWN_REQUEST),
	.OUTPUT_DISABLE_PIN(OUTPUT_DISABLE_PIN), .DATA_A_OE(DATA_A_OE), .DATA_B_OE(DATA_B_OE),
	.DATA_CLOCK_OUT_A(DATA_CLOCK_OUT_A), .DATA_CLOCK_OUT_B(DATA_CLOCK_OUT_B), .DATA_CLOCK_OE(DATA_CLOCK_OE));
`default_nettype wire

// >>> dv/aopc_capture.sv
`timescale 1ns/1ns
`default_nettype none
module aopc_capture (
	// Data clock and bus from the converter
	input wire logic        dck,
	input wire logic        oe,
	input wire logic [11:0] data,
	input wire logic        or_flag,
	// Latched word, flag on top
	output logic     [12:0] word
);
	logic [12:0] bus_val;
	// Released bus shows the inverse, so a stale word never passes
	always_comb bus_val = oe ? {or_flag, data} : ~word;
	// Capture on the rising data clock edge
	always_ff @(posedge dck) begin
		word <= bus_val;
	end
endmodule
`default_nettype wire

// >>> dv/aopc_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module aopc_top_bench;
	import aopc_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, sclk = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000, rd;
	logic [13:0] sa = 14'h0000, sb = 14'h0000;
	logic        pdr = 1'b0, odp = 1'b0, fsp = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, ora, orb, oea, output_disable, dcoa, dcob, dcoe, irq;
	logic [1:0]  bresp, rs, rresp;
	aopc_word_t  rdata;
	logic [11:0] da, db, e;
	logic [12:0] cap;
	int          n_fail = 0, check_count = 0, cyc = 0, w1, w2;
	// Inputs in half-LSB units and expected {flag, offset binary}
	logic [13:0] xs [5] = '{14'h0FFF, 14'h1000, 14'h0000, 14'h2FFF, 14'h2FFE};
	logic [12:0] ex [5] = '{13'h0FFF, 13'h1FFF, 13'h0800, 13'h0000, 13'h1000};

	aopc_top #(.DOWN_CW(8)) aopc_top_inst (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.SAMPLE_CLK(sclk), .SAMPLE_A(sa), .SAMPLE_B(sb), .POWER_DOWN_REQUEST(pdr),
		.OUTPUT_DISABLE_PIN(odp), .FORMAT_SELECT_PIN(fsp), .DATA_A(da), .OR_A(ora), .DATA_A_OE(oea),
		.DATA_B(db), .OR_B(orb), .DATA_B_OE(output_disable), .DATA_CLOCK_OUT_A(dcoa), .DATA_CLOCK_OUT_B(dcob),
		.DATA_CLOCK_OE(dcoe), .IRQ(irq));
	aopc_capture aopc_capture_inst (.dck(dcoa), .oe(oea), .data(da), .or_flag(ora), .word(cap));

	// System clock, and a sample clock off the system edges
	initial forever #2 clk = ~clk;
	initial begin
		#5;
		forever #24 sclk = ~sclk;
	end
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_fail++;
			give_verdict();
		end
	end

	task give_verdict();
		if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	// Each channel released at its own handshake edge
	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask
	task axi_rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	// Ends eight system clocks after the n-th sample rise, mid-word
	task srise(input int n);
		repeat (n) @(posedge sclk);
		repeat (8) @(posedge clk);
	endtask
	task wake(output int w);
		w = 0;
		while (oea !== 1'b1 && w < 3000) begin
			@(posedge clk);
			w++;
		end
	endtask
	task pd(input int dur, output int w);
		pdr <= 1'b1;
		repeat (dur) @(posedge clk);
		check({oea, output_disable, dcoe}, 3'b000);
		pdr <= 1'b0;
		wake(w);
		check(oea, 1'b1);
	endtask

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		axi_rd(8'h00);
		check(rd, 32'h0);
		axi_rd(8'h08);
		check(rd, 32'h0);
		axi_rd(8'h14);
		check(rd, 32'h0);
		axi_rd(8'h10);
		check({rs, rd}, {2'b10, 32'h0});
		// Every code point under every format source
		for (int i = 0; i < 5; i++) begin
			for (int f = 0; f < 5; f++) begin
				sa <= xs[i];
				sb <= xs[i];
				fsp <= (f == 1 || f == 2);
				axi_wr(8'h00, f < 2 ? 32'h0 : (f == 2 ? 32'h04 : (f == 3 ? 32'h14 : 32'h24)));
				srise(14);
				e = ex[i][11:0] ^ ((f == 1 || f == 3) ? 12'h800 : 12'h000);
				if (f == 4) e = e ^ (e >> 1);
				check({ora, da}, {ex[i][12], e});
				check({orb, db}, {ex[i][12], e});
				check(cap, {ex[i][12], e});
			end
		end
		// Latency: new word only at the thirteenth rise after the change
		axi_wr(8'h00, 32'h0);
		fsp <= 1'b0;
		sa <= 14'h0000;
		srise(14);
		srise(1);
		sa <= 14'h0FFF;
		srise(12);
		check(da, 12'h800);
		srise(1);
		check(da, 12'hFFF);
		// Wake-up grows with time down; masked event leaves the line low
		pd(40, w1);
		check(irq, 1'b0);
		pd(240, w2);
		check(w2 > w1 + 8, 1'b1);
		axi_wr(8'h08, 32'h8);
		axi_rd(8'h04);
		pd(40, w1);
		check(irq, 1'b1);
		axi_rd(8'h04);
		check(rd & 32'h8, 32'h8);
		repeat (2) @(posedge clk);
		check(irq, 1'b0);
		// Standby and register power-down
		axi_wr(8'h00, 32'h2);
		repeat (10) @(posedge clk);
		axi_rd(8'h0C);
		check({rd[1:0], oea, output_disable}, 4'b1000);
		axi_wr(8'h00, 32'h0);
		wake(w1);
		check(w1 >= 40 && w1 <= 60, 1'b1);
		axi_wr(8'h00, 32'h1);
		repeat (6) @(posedge clk);
		axi_rd(8'h0C);
		check({rd[1:0], oea, output_disable, dcoe}, 5'b01000);
		axi_wr(8'h00, 32'h0);
		wake(w1);
		// Disable pin, then one channel at a time
		odp <= 1'b1;
		repeat (8) @(posedge clk);
		check({oea, output_disable}, 2'b00);
		odp <= 1'b0;
		repeat (8) @(posedge clk);
		check({oea, output_disable}, 2'b11);
		axi_wr(8'h14, 32'h1);
		repeat (4) @(posedge clk);
		check({oea, output_disable}, 2'b01);
		axi_wr(8'h14, 32'h2);
		repeat (4) @(posedge clk);
		check({oea, output_disable}, 2'b10);
		axi_wr(8'h14, 32'h0);
		// Data clock low mid-word, high when inverted
		srise(1);
		check({dcoa, dcob}, 2'b00);
		axi_wr(8'h00, 32'h40);
		srise(1);
		check({dcoa, dcob}, 2'b11);
		give_verdict();
	end
endmodule
`default_nettype wire
